/* File: verilog/rtc_pkg.sv */
// Constants and types for the slow-counter control and status block.
// Assumes a 100 MHz bus clock and a 32.768 kHz slow source on pins.
package rtc_pkg;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_YEAR_LOAD = 8'h04;
   localparam logic [7:0] OFF_YEAR_MATCH0 = 8'h08;
   localparam logic [7:0] OFF_YEAR_MATCH1 = 8'h0C;
   localparam logic [7:0] OFF_YEAR_MATCH2 = 8'h10;
   localparam logic [7:0] OFF_YEAR_TRIM = 8'h14;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int BIT_OSC_BYPASS = 14;
   localparam int BIT_RT_TRIM_BYPASS = 12;
   localparam int BIT_YEAR_TRIM_BYPASS = 10;
   localparam int BIT_OSC_ENABLE = 8;
   localparam int BIT_CTRL_WRITE_PENDING = 7;
   localparam int BIT_OSC_RUNNING = 5;
   localparam int BIT_YEAR_TRIM_WRITE_PENDING = 4;
   localparam int BIT_YEAR_MATCH2_WRITE_PENDING = 3;
   localparam int BIT_YEAR_MATCH1_WRITE_PENDING = 2;
   localparam int BIT_YEAR_MATCH0_WRITE_PENDING = 1;
   localparam int BIT_YEAR_LOAD_WRITE_PENDING = 0;

   // ------------------------------------------------------------
   // Pending slots: 0 load, 1..3 match0..2, 4 trim, 5 control
   // ------------------------------------------------------------
   localparam int NUM_DATA = 5;
   localparam int NUM_SLOTS = 6;
   localparam int SLOT_CTRL = 5;

   // ------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------
   localparam logic [31:0] RESET_DATA = 32'h0000_0000;
   localparam logic OSC_RUNNING_RESET = 1'b0;
   localparam int CLK_PERIOD_NS = 10;
   localparam int OSC_LOSS_NS = 61036;
   localparam int OSC_LOSS_CYCLES =
      (OSC_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EDGES_FOR_RUNNING = 2;

   typedef struct packed {
      logic osc_bypass;
      logic rt_trim_bypass;
      logic year_trim_bypass;
      logic osc_enable;
   } rtc_ctrl_t;

   localparam rtc_ctrl_t CTRL_RESET = 4'h0;

endpackage

/* File: verilog/rtc_pend_cell.sv */
// One write-pending flag that tracks a value crossing to the slow side.
// Assumes slow_edge is a one-cycle pulse per slow-clock rising edge.
`timescale 1ns/1ps
module rtc_pend_cell
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Events
   input wire logic set_req,
   input wire logic slow_edge,
   // Status
   output logic pending,
   output logic commit
);

   // A new write in the same cycle as the slow edge keeps the flag set.
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         pending <= 1'b0;
      else if (set_req)
         pending <= 1'b1;
      else if (slow_edge)
         pending <= 1'b0;
   end

   assign commit = pending & slow_edge & ~set_req;

endmodule

/* File: verilog/rtc_cntr_ctrl.sv */
// APB control and status for the real-time and time-of-year counters.
// Assumes slow pins are synchronous to clk and trim ticks come from outside.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps

// Functional notes
// - Real-time trim bypass set: count raw slow edges, else trimmed ticks.
// - Year trim bypass set: count raw slow edges, else trimmed ticks.
// - Oscillator enable gates the slow clock into both counters.
// - Running flag reads one after two enabled slow edges, each within two slow periods of the one before.
// - Bits 4..0 flag pending writes to trim, matches and load.
// - Bit 7 flags a pending write to the control register.
// - Oscillator bypass set: counters run from general-purpose pin 8.
module rtc_cntr_ctrl
   import rtc_pkg::*;
#(
   parameter int LOSS_CYCLES = OSC_LOSS_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Slow clock sources
   input wire logic slow_xtal_in,
   output logic slow_xtal_out,
   input wire logic gpio8_in,
   // Trim tick inputs
   input wire logic rt_trim_tick,
   input wire logic year_trim_tick,
   // Counter side
   output logic rt_count_tick,
   output logic year_count_tick,
   output rtc_ctrl_t ctrl_active,
   output logic [NUM_DATA-1:0][31:0] year_regs,
   output logic year_load_pulse
);

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic access;
   logic setup;
   logic mapped;
   logic is_ctrl;
   logic [2:0] data_idx;
   logic [NUM_SLOTS-1:0] wr_slot;

   assign access = psel & penable;
   assign setup = psel & ~penable;
   assign is_ctrl = (paddr == OFF_CTRL);
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFF_YEAR_TRIM);
   assign data_idx = 3'(paddr[4:2] - 3'h1);
   // No wait states: every access completes in its first access cycle.
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // ------------------------------------------------------------
   // Shadow registers written on the bus side
   // ------------------------------------------------------------
   rtc_ctrl_t ctrl_shadow;
   logic [NUM_DATA-1:0][31:0] data_shadow;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ctrl_shadow <= CTRL_RESET;
      else if (wr_slot[SLOT_CTRL])
      begin
         ctrl_shadow.osc_bypass <= pwdata[BIT_OSC_BYPASS];
         ctrl_shadow.rt_trim_bypass <= pwdata[BIT_RT_TRIM_BYPASS];
         ctrl_shadow.year_trim_bypass <= pwdata[BIT_YEAR_TRIM_BYPASS];
         ctrl_shadow.osc_enable <= pwdata[BIT_OSC_ENABLE];
      end
   end

   // ------------------------------------------------------------
   // Slow clock edge on the selected source
   // ------------------------------------------------------------
   logic slow_src;
   logic slow_prev;
   logic slow_edge;
   logic gated_edge;

   assign slow_src = ctrl_active.osc_bypass ? gpio8_in : slow_xtal_in;
   assign slow_edge = slow_src & ~slow_prev;
   assign gated_edge = slow_edge & ctrl_active.osc_enable;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         slow_prev <= 1'b0;
      else
         slow_prev <= slow_src;
   end

   // Feedback for the crystal is held quiet while the oscillator is off.
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         slow_xtal_out <= 1'b0;
      else
         slow_xtal_out <= ctrl_active.osc_enable & ~slow_xtal_in;
   end

   // ------------------------------------------------------------
   // Write-pending flags, one per slow-side register
   // ------------------------------------------------------------
   logic [NUM_SLOTS-1:0] pend;
   logic [NUM_SLOTS-1:0] commit;

   // Commits ride on the ungated edge so a disable can itself land.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SLOTS; gi++)
      begin : g_slot
         if (gi == SLOT_CTRL)
         begin : g_ctrl
            assign wr_slot[gi] = access & pwrite & is_ctrl;
         end
         else
         begin : g_data
            assign wr_slot[gi] = access & pwrite & mapped & ~is_ctrl &
               (data_idx == 3'(gi));
            always_ff @(posedge clk or posedge reset)
            begin
               if (reset)
                  data_shadow[gi] <= RESET_DATA;
               else if (wr_slot[gi])
                  data_shadow[gi] <= pwdata;
            end
            always_ff @(posedge clk or posedge reset)
            begin
               if (reset)
                  year_regs[gi] <= RESET_DATA;
               else if (commit[gi])
                  year_regs[gi] <= data_shadow[gi];
            end
         end
         rtc_pend_cell u_pend
         (
            .clk(clk),
            .reset(reset),
            .set_req(wr_slot[gi]),
            .slow_edge(slow_edge),
            .pending(pend[gi]),
            .commit(commit[gi])
         );
      end
   endgenerate

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ctrl_active <= CTRL_RESET;
      else if (commit[SLOT_CTRL])
         ctrl_active <= ctrl_shadow;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         year_load_pulse <= 1'b0;
      else
         year_load_pulse <= commit[0];
   end

   // ------------------------------------------------------------
   // Oscillator running detector
   // ------------------------------------------------------------
   logic [15:0] since_edge;
   logic [1:0] edge_count;
   logic osc_running;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         since_edge <= 16'h0000;
      else if (gated_edge)
         since_edge <= 16'h0000;
      else if (since_edge < 16'(LOSS_CYCLES))
         since_edge <= since_edge + 16'h0001;
   end

   // A gap longer than two slow periods means the clock has stopped.
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         edge_count <= 2'b00;
      else if (~ctrl_active.osc_enable || since_edge >= 16'(LOSS_CYCLES))
         edge_count <= 2'b00;
      else if (gated_edge && edge_count < 2'(EDGES_FOR_RUNNING))
         edge_count <= edge_count + 2'b01;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         osc_running <= OSC_RUNNING_RESET;
      else
         osc_running <= (edge_count == 2'(EDGES_FOR_RUNNING));
   end

   // ------------------------------------------------------------
   // Counter ticks
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rt_count_tick <= 1'b0;
         year_count_tick <= 1'b0;
      end
      else
      begin
         rt_count_tick <= ctrl_active.osc_enable &
            (ctrl_active.rt_trim_bypass ? slow_edge : rt_trim_tick);
         year_count_tick <= ctrl_active.osc_enable &
            (ctrl_active.year_trim_bypass ? slow_edge
                                          : year_trim_tick);
      end
   end

   // ------------------------------------------------------------
   // Read data, captured in the setup cycle
   // ------------------------------------------------------------
   logic [31:0] next_rdata;

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (is_ctrl)
      begin
         next_rdata[BIT_OSC_BYPASS] = ctrl_shadow.osc_bypass;
         next_rdata[BIT_RT_TRIM_BYPASS] = ctrl_shadow.rt_trim_bypass;
         next_rdata[BIT_YEAR_TRIM_BYPASS] = ctrl_shadow.year_trim_bypass;
         next_rdata[BIT_OSC_ENABLE] = ctrl_shadow.osc_enable;
         next_rdata[BIT_CTRL_WRITE_PENDING] = pend[SLOT_CTRL];
         next_rdata[BIT_OSC_RUNNING] = osc_running;
         next_rdata[BIT_YEAR_TRIM_WRITE_PENDING] = pend[4];
         next_rdata[BIT_YEAR_MATCH2_WRITE_PENDING] = pend[3];
         next_rdata[BIT_YEAR_MATCH1_WRITE_PENDING] = pend[2];
         next_rdata[BIT_YEAR_MATCH0_WRITE_PENDING] = pend[1];
         next_rdata[BIT_YEAR_LOAD_WRITE_PENDING] = pend[0];
      end
      else if (mapped)
         next_rdata = data_shadow[data_idx];
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         prdata <= 32'h0000_0000;
      else if (setup & ~pwrite)
         prdata <= next_rdata;
   end

endmodule

/* File: tb/rtc_cntr_ctrl_assertions.sv */
// Port-level checker for the counter control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module rtc_cntr_ctrl_assertions
   import rtc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Slow side
   input wire logic slow_xtal_in,
   input wire logic slow_xtal_out,
   input wire logic gpio8_in,
   input wire logic rt_trim_tick,
   input wire logic year_trim_tick,
   input wire logic rt_count_tick,
   input wire logic year_count_tick,
   input wire rtc_ctrl_t ctrl_active,
   input wire logic [NUM_DATA-1:0][31:0] year_regs,
   input wire logic year_load_pulse
);
   logic src_q;
   logic gpio_q;
   wire logic src = ctrl_active.osc_bypass ? gpio8_in : slow_xtal_in;
   wire logic rise = src && !src_q;
   wire logic on = ctrl_active.osc_enable;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset) {src_q, gpio_q} <= 2'h0;
      else {src_q, gpio_q} <= {src, gpio8_in};
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_rt_bypass: assert property (
      rise && on && ctrl_active.rt_trim_bypass |=> rt_count_tick)
      else $error("raw tick missing");
   a_rt_trimmed: assert property (
      rt_trim_tick && on && !ctrl_active.rt_trim_bypass |=> rt_count_tick)
      else $error("trimmed tick missing");
   a_no_stray: assert property (
      !rise && !rt_trim_tick |=> !rt_count_tick)
      else $error("tick without cause");
   a_year_bypass: assert property (
      rise && on && ctrl_active.year_trim_bypass |=> year_count_tick)
      else $error("year raw tick missing");
   a_year_trimmed: assert property (
      year_trim_tick && on && !ctrl_active.year_trim_bypass
      |=> year_count_tick) else $error("year trimmed tick missing");
   a_gate_off: assert property (
      !on |=> !rt_count_tick && !year_count_tick)
      else $error("tick while gated off");
   a_gpio_drives: assert property (
      ctrl_active.osc_bypass && on && ctrl_active.rt_trim_bypass
      && gpio8_in && !gpio_q |=> rt_count_tick)
      else $error("pin edge did not tick");
   a_commit_edge: assert property (
      $changed({ctrl_active, year_regs}) |-> $past(rise))
      else $error("commit without slow edge");
   a_load_pulse: assert property (
      year_load_pulse |-> $past(rise))
      else $error("load pulse without commit");
   a_xtal_quiet: assert property (
      !on |=> !slow_xtal_out)
      else $error("crystal feedback active while disabled");
   a_unmapped_err: assert property (
      psel && penable |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0))
      else $error("error response wrong");

   // Why: shows the pin source and a refused access were exercised.
   c_pin_tick: cover property (rt_count_tick && ctrl_active.osc_bypass);
   c_load: cover property (year_load_pulse);
   c_refused: cover property (psel && penable && pslverr);
endmodule

/* File: tb/rtc_cntr_ctrl_tb.sv */
// Self-checking bench for the counter control block.
// Assumes slow sources are toggled on the bench clock, 6 cycles apart.
`timescale 1ns/1ps
module rtc_cntr_ctrl_tb import rtc_pkg::*;;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, slow_xtal_out, rt_count_tick, year_count_tick;
   logic slow_xtal_in = 1'h0, gpio8_in = 1'h0;
   logic rt_trim_tick = 1'h0, year_trim_tick = 1'h0, year_load_pulse;
   rtc_ctrl_t ctrl_active;
   logic [NUM_DATA-1:0][31:0] year_regs;
   logic xtal_run = 1'h0, gpio_run = 1'h0;
   int ph = 0, fail_count = 0, samples_checked = 0;
   logic [31:0] exp_q[$];
   logic [31:0] vals[NUM_DATA];

   // Loss count shortened so a stopped source is noticed quickly.
   rtc_cntr_ctrl #(.LOSS_CYCLES(40)) u_dut (
      .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .slow_xtal_in, .slow_xtal_out, .gpio8_in,
      .rt_trim_tick, .year_trim_tick, .rt_count_tick, .year_count_tick,
      .ctrl_active, .year_regs, .year_load_pulse);

   initial forever #5 clk = ~clk;

   always @(posedge clk)
   begin
      ph <= ph + 1;
      if (ph % 6 == 5 && xtal_run) slow_xtal_in <= ~slow_xtal_in;
      if (ph % 6 == 5 && gpio_run) gpio8_in <= ~gpio8_in;
      rt_trim_tick <= ($urandom % 8) == 0;
      year_trim_tick <= ($urandom % 8) == 0;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'h0, a, 32'h0);
   endtask

   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask

   task test_done;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk)
      if (psel && penable && !pwrite && pready === 1'h1)
         chk(prdata, exp_q.pop_front());

   initial
   begin
      wt(20000);
      fail_count++;
      test_done;
   end

   initial
   begin
      void'($urandom(32'h3EC3C70B));
      wt(2);
      reset <= 1'h0;
      rd(OFF_CTRL, 32'h0);
      // Read-only and reserved bits are written to prove they are ignored.
      apb(1'h1, OFF_CTRL, 32'h3DA0);
      rd(OFF_CTRL, 32'h1580);
      xtal_run <= 1'h1;
      wt(60);
      chk({28'h0, ctrl_active}, 32'h7);
      rd(OFF_CTRL, 32'h1520);
      xtal_run <= 1'h0;
      wt(60);
      rd(OFF_CTRL, 32'h1500);
      foreach (vals[i])
      begin
         vals[i] = $urandom;
         apb(1'h1, OFF_YEAR_LOAD + 8'(4 * i), vals[i]);
      end
      rd(OFF_CTRL, 32'h151F);
      chk(year_regs[0], 32'h0);
      xtal_run <= 1'h1;
      for (int i = 0; i < 200 && year_regs[4] !== vals[4]; i++) wt(1);
      wt(40);
      foreach (vals[i]) chk(year_regs[i], vals[i]);
      rd(OFF_CTRL, 32'h1520);
      gpio_run <= 1'h1;
      apb(1'h1, OFF_CTRL, 32'h5500);
      wt(40);
      xtal_run <= 1'h0;
      wt(60);
      rd(OFF_CTRL, 32'h5520);
      apb(1'h1, OFF_CTRL, 32'h4100);
      wt(60);
      rd(OFF_CTRL, 32'h4120);
      apb(1'h1, OFF_CTRL, 32'h4000);
      wt(60);
      rd(OFF_CTRL, 32'h4000);
      apb(1'h1, 8'h18, 32'hFFFF_FFFF);
      rd(8'h18, 32'h0);
      rd(8'h02, 32'h0);
      test_done;
   end
endmodule

bind rtc_cntr_ctrl rtc_cntr_ctrl_assertions u_chk (
   .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .slow_xtal_in, .slow_xtal_out, .gpio8_in,
   .rt_trim_tick, .year_trim_tick, .rt_count_tick, .year_count_tick,
   .ctrl_active, .year_regs, .year_load_pulse);
